//--- contactor_model.sv
`timescale 1ns/1ns
`default_nettype none
module contactor_model #(
    parameter int travel = 3
) (
    input wire logic clk,
    input wire logic close_cmd,
    input wire logic stuck_open,
    input wire logic stuck_closed,
    output logic fb_n
);
    int cnt = 0;
    logic shut = 1'b0;
    // The armature needs a few cycles to travel either way.
    always @(posedge clk) begin
        if (close_cmd != shut && cnt < travel) begin
            cnt <= cnt + 1;
        end else begin
            cnt <= 0;
            shut <= close_cmd;
        end
    end
    // The pin is pulled up, so an open contact reads high.
    assign fb_n = ~((shut & ~stuck_open) | stuck_closed);
endmodule // contactor_model
`default_nettype wire

//--- contactor_pkg.sv
package contactor_pkg;

    // Register byte offsets.
    localparam logic [11:0] ctrl_off = 12'h000;
    localparam logic [11:0] run_dly_off = 12'h004;
    localparam logic [11:0] open_dly_off = 12'h008;
    localparam logic [11:0] state_off = 12'h00C;
    localparam logic [11:0] irq_status_off = 12'h010;
    localparam logic [11:0] irq_enable_off = 12'h014;
    localparam logic [11:0] irq_clear_off = 12'h018;

    // Control register field positions.
    localparam int ctrl_drive_en_bit = 0;
    localparam int ctrl_fb_en_bit = 1;

    // Status and interrupt field positions.
    localparam int err_open_bit = 0;
    localparam int err_closed_bit = 1;

    // Delays are held in hundredths of a second.
    localparam logic [12:0] run_dly_reset = 13'h000F;
    localparam logic [12:0] open_dly_reset = 13'h000A;
    localparam logic [12:0] run_dly_max = 13'h1770;
    localparam logic [12:0] open_dly_max = 13'h01F4;
    localparam logic [1:0] ctrl_reset = 2'h0;

    // One tick every 10 ms at the 20 MHz control clock.
    localparam int clk_hz = 20000000;
    localparam int tick_ms = 10;
    localparam int tick_cycles = clk_hz / 1000 * tick_ms;
    localparam logic [17:0] tick_last = 18'(tick_cycles - 1);

    typedef enum logic [3:0] {
        st_idle = 4'h1,
        st_closing = 4'h2,
        st_running = 4'h4,
        st_opening = 4'h8
    } seq_e;

    typedef struct packed {
        logic run_cmd;
        logic current_on;
        logic dc_brake;
        logic feedback_in;
    } drive_in_s;

    typedef struct packed {
        seq_e st;
        logic [17:0] div;
        logic tick;
        logic [12:0] cnt;
        logic [1:0] ctrl;
        logic [12:0] run_dly;
        logic [12:0] open_dly;
        logic [1:0] irq_status;
        logic [1:0] irq_enable;
        logic irq;
        logic [1:0] fb_sync;
        logic run_prev;
        logic drive_out;
        logic motor_en;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_s;

endpackage

//--- output_contactor_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// - With drive output used, request contactor close when run command becomes active.
// - Request contactor open once no motor current is applied.
// - Feedback unassigned disables both contactor error checks.
// - Opened error when feedback not closed at run delay, or opens while running.
// - Closed error when feedback not open at open delay, or closes while stopped.
// - Falling run command clears a latched opened-contact error.
// - Drive output and feedback input each usable without the other.
// - During DC injection braking keep contactor open, no close request.
// - Feedback low means closed; motor runs only after it reads 0.
// - Monitor-only mode holds motor control off for the run delay; the code enables the motor as soon as feedback reads closed.
// - Opened error not evaluated until run delay elapsed after run command.
// - Run delay in hundredths of a second, reset default 0.15 s.
// - Open delay zero to five seconds in hundredths, default 0.10 s.
// - Feedback not 1 when open delay expires raises closed error.
// - Open delay of zero disables closed-contact supervision.
module output_contactor_sequencer
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire contactor_pkg::drive_in_s drive_in,
    output logic contactor_drive_output,
    output logic motor_enable,
    output logic irq
);
    import contactor_pkg::*;

    state_s s_r;
    state_s s_nxt;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [12:0] clamp_delay(input logic [31:0] v, input logic [12:0] lim);
        clamp_delay = (v > {19'h0, lim}) ? lim : v[12:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic drive_en;
    logic fb_en;
    logic fb_closed;
    logic run_fall;
    logic access;
    logic [1:0] ev;
    logic [1:0] clr;

    always_comb begin
        s_nxt = s_r;
        drive_en = s_r.ctrl[ctrl_drive_en_bit];
        fb_en = s_r.ctrl[ctrl_fb_en_bit];
        fb_closed = ~s_r.fb_sync[1];
        run_fall = s_r.run_prev & ~drive_in.run_cmd;
        access = psel & penable;
        ev = 2'h0;
        clr = 2'h0;

        // Pin feedback passes two flops; only the second one is read.
        s_nxt.fb_sync = {s_r.fb_sync[0], drive_in.feedback_in};
        s_nxt.run_prev = drive_in.run_cmd;

        // Ten millisecond time base for both delays.
        s_nxt.tick = 1'b0;
        if (s_r.div == tick_last) begin
            s_nxt.div = 18'h0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.div = s_r.div + 18'h1;
        end

        case (s_r.st)
            st_idle: begin
                s_nxt.drive_out = 1'b0;
                s_nxt.motor_en = 1'b0;
                // Close request waits out DC braking; a latched opened error blocks a restart.
                if (drive_in.run_cmd && !drive_in.dc_brake &&
                        !s_r.irq_status[err_open_bit]) begin
                    s_nxt.cnt = 13'h0;
                    s_nxt.st = st_closing;
                    s_nxt.drive_out = drive_en;
                end else if (fb_en && fb_closed) begin
                    ev[err_closed_bit] = 1'b1;
                end
            end
            st_closing: begin
                s_nxt.drive_out = drive_en & ~drive_in.dc_brake;
                if (s_r.tick) begin
                    s_nxt.cnt = s_r.cnt + 13'h1;
                end
                if (!drive_in.run_cmd) begin
                    // A contact that already closed gets its open delay before idle checks it.
                    s_nxt.cnt = 13'h0;
                    s_nxt.st = st_opening;
                    s_nxt.drive_out = 1'b0;
                end else if (fb_en) begin
                    // Feedback low starts the motor; no error before the delay.
                    if (fb_closed) begin
                        s_nxt.st = st_running;
                        s_nxt.motor_en = 1'b1;
                    end else if (s_r.cnt >= s_r.run_dly) begin
                        ev[err_open_bit] = 1'b1;
                        s_nxt.st = st_idle;
                        s_nxt.drive_out = 1'b0;
                    end
                end else if (s_r.cnt >= s_r.run_dly) begin
                    // No feedback: run delay alone gates motor control.
                    s_nxt.st = st_running;
                    s_nxt.motor_en = 1'b1;
                end
            end
            st_running: begin
                if (fb_en && !fb_closed) begin
                    ev[err_open_bit] = 1'b1;
                    s_nxt.motor_en = 1'b0;
                    s_nxt.drive_out = 1'b0;
                    s_nxt.st = st_idle;
                end else if (!drive_in.run_cmd) begin
                    s_nxt.motor_en = 1'b0;
                    s_nxt.cnt = 13'h0;
                    s_nxt.st = st_opening;
                end
            end
            st_opening: begin
                // Contactor held until current stops flowing.
                if (!drive_in.current_on) begin
                    s_nxt.drive_out = 1'b0;
                    if (s_r.tick) begin
                        s_nxt.cnt = s_r.cnt + 13'h1;
                    end
                    // Zero open delay or unused feedback skips the check.
                    if (!fb_en || s_r.open_dly == 13'h0) begin
                        s_nxt.st = st_idle;
                    end else if (!fb_closed) begin
                        s_nxt.st = st_idle;
                    end else if (s_r.cnt >= s_r.open_dly) begin
                        ev[err_closed_bit] = 1'b1;
                        s_nxt.st = st_idle;
                    end
                end else begin
                    s_nxt.cnt = 13'h0;
                end
            end
            default: begin
                s_nxt.st = st_idle;
            end
        endcase

        // Idle-closed check skipped when open delay disables it.
        if (s_r.open_dly == 13'h0) begin
            ev[err_closed_bit] = ev[err_closed_bit] & (s_r.st != st_idle);
        end
        if (s_r.st == st_idle && s_r.open_dly == 13'h0) begin
            ev[err_closed_bit] = 1'b0;
        end

        // APB slave: pready comes one cycle into the access phase, so each access has one wait state.
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (access && !s_r.pready) begin
            s_nxt.pready = 1'b1;
            if (pwrite) begin
                if (paddr == ctrl_off) begin
                    s_nxt.ctrl = pwdata[1:0];
                end else if (paddr == run_dly_off) begin
                    s_nxt.run_dly = clamp_delay(pwdata, run_dly_max);
                end else if (paddr == open_dly_off) begin
                    s_nxt.open_dly = clamp_delay(pwdata, open_dly_max);
                end else if (paddr == irq_enable_off) begin
                    s_nxt.irq_enable = pwdata[1:0];
                end else if (paddr == irq_clear_off) begin
                    clr = pwdata[1:0];
                end else if (paddr != state_off && paddr != irq_status_off) begin
                    s_nxt.pslverr = 1'b1;
                end
            end else begin
                s_nxt.prdata = 32'h0;
                if (paddr == ctrl_off) begin
                    s_nxt.prdata = {30'h0, s_r.ctrl};
                end else if (paddr == run_dly_off) begin
                    s_nxt.prdata = {19'h0, s_r.run_dly};
                end else if (paddr == open_dly_off) begin
                    s_nxt.prdata = {19'h0, s_r.open_dly};
                end else if (paddr == state_off) begin
                    s_nxt.prdata = {24'h0, s_r.motor_en, s_r.drive_out, fb_closed, 1'b0, s_r.st};
                end else if (paddr == irq_status_off) begin
                    s_nxt.prdata = {30'h0, s_r.irq_status};
                end else if (paddr == irq_enable_off) begin
                    s_nxt.prdata = {30'h0, s_r.irq_enable};
                end else if (paddr != irq_clear_off) begin
                    s_nxt.pslverr = 1'b1;
                end
            end
        end

        // Falling run command clears the opened error.
        if (run_fall) begin
            clr[err_open_bit] = 1'b1;
        end
        // Sticky flags: a new event wins over a clear.
        s_nxt.irq_status = (s_r.irq_status & ~clr) | ev;
        s_nxt.irq = |(s_nxt.irq_status & s_r.irq_enable);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{st: st_idle, div: 18'h0, tick: 1'b0, cnt: 13'h0, ctrl: ctrl_reset,
                     run_dly: run_dly_reset, open_dly: open_dly_reset, irq_status: 2'h0,
                     irq_enable: 2'h0, irq: 1'b0, fb_sync: 2'h3, run_prev: 1'b0,
                     drive_out: 1'b0, motor_en: 1'b0, pready: 1'b0, pslverr: 1'b0,
                     prdata: 32'h0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign contactor_drive_output = s_r.drive_out;
    assign motor_enable = s_r.motor_en;
    assign irq = s_r.irq;

endmodule // output_contactor_sequencer
`default_nettype wire

//--- output_contactor_sequencer_properties.sv
`timescale 1ns/1ns
`default_nettype none
module contactor_check
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire contactor_pkg::drive_in_s drive_in,
    input wire logic contactor_drive_output,
    input wire logic motor_enable
);
    import contactor_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_after_access_a: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered in one cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside an access");
    slverr_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    brake_no_close_a: assert property (
        $past(drive_in.dc_brake) && $past(drive_in.dc_brake, 2) |-> !$rose(contactor_drive_output))
        else $error("contactor closed during braking");
    close_after_run_a: assert property (
        $rose(contactor_drive_output) |-> $past(drive_in.run_cmd) || $past(drive_in.run_cmd, 2))
        else $error("close request without run command");
    motor_needs_run_a: assert property (
        motor_enable |-> drive_in.run_cmd || $past(drive_in.run_cmd))
        else $error("motor enabled without run command");
    drive_release_a: assert property (
        (!drive_in.run_cmd && !drive_in.current_on) [*3] |=> !contactor_drive_output)
        else $error("contactor held with no current");
endmodule // contactor_check
bind output_contactor_sequencer contactor_check u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .drive_in(drive_in),
    .contactor_drive_output(contactor_drive_output), .motor_enable(motor_enable));
`default_nettype wire

//--- output_contactor_sequencer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module output_contactor_sequencer_tb_top;
    import contactor_pkg::*;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr;
    logic run, cur, brake, fb, so, sc, drv, men, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    drive_in_s din;
    int num_errors = 0;
    int n_tests = 0;
    // Fields: error expected, write, address, data (read data expected on reads).
    localparam logic [45:0] rows [8] = '{
        {2'b00, ctrl_off, 32'h0}, {2'b00, run_dly_off, 32'(run_dly_reset)},
        {2'b00, open_dly_off, 32'(open_dly_reset)}, {2'b00, irq_status_off, 32'h0},
        {2'b00, irq_enable_off, 32'h0}, {2'b10, 12'h01C, 32'h0},
        {2'b01, run_dly_off, 32'h2000}, {2'b00, run_dly_off, 32'(run_dly_max)}};
    assign din = {run, cur, brake, fb};
    always #25 pclk = ~pclk;
    output_contactor_sequencer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .drive_in(din), .contactor_drive_output(drv),
        .motor_enable(men), .irq(irq));
    contactor_model u_ct (.clk(pclk), .close_cmd(drv), .stuck_open(so), .stuck_closed(sc),
        .fb_n(fb));
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic ee);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        chk({pready, pslverr}, {1'b1, ee});
        if (!w) chk(prdata, d);
    endtask
    task automatic pause;
        repeat (12) @(posedge pclk);
    endtask
    task automatic end_of_test;
        if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, run, cur, brake, so, sc, presetn} = '0;
        paddr = '0;
        pwdata = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            xfer(rows[i][44], rows[i][43:32], rows[i][31:0], rows[i][45]);
        end
        chk({drv, men, irq}, 3'h0);
        xfer(1'b1, ctrl_off, 32'h3, 1'b0);
        xfer(1'b1, irq_enable_off, 32'h3, 1'b0);
        brake <= 1'b1;
        run <= 1'b1;
        cur <= 1'b1;
        pause;
        chk(drv, 1'b0);
        brake <= 1'b0;
        pause;
        chk({drv, men}, 2'h3);
        so <= 1'b1;
        pause;
        chk({drv, men, irq}, 3'h1);
        xfer(1'b0, irq_status_off, 32'h1, 1'b0);
        so <= 1'b0;
        run <= 1'b0;
        cur <= 1'b0;
        pause;
        xfer(1'b0, irq_status_off, 32'h0, 1'b0);
        sc <= 1'b1;
        pause;
        xfer(1'b0, irq_status_off, 32'h2, 1'b0);
        chk(irq, 1'b1);
        xfer(1'b1, irq_clear_off, 32'h2, 1'b0);
        xfer(1'b0, irq_status_off, 32'h2, 1'b0);
        xfer(1'b1, irq_enable_off, 32'h1, 1'b0);
        @(posedge pclk);
        chk(irq, 1'b0);
        sc <= 1'b0;
        pause;
        xfer(1'b1, irq_clear_off, 32'h3, 1'b0);
        xfer(1'b0, irq_status_off, 32'h0, 1'b0);
        xfer(1'b1, open_dly_off, 32'h0, 1'b0);
        sc <= 1'b1;
        pause;
        xfer(1'b0, irq_status_off, 32'h0, 1'b0);
        xfer(1'b1, ctrl_off, 32'h1, 1'b0);
        xfer(1'b1, open_dly_off, 32'h5, 1'b0);
        pause;
        xfer(1'b0, irq_status_off, 32'h0, 1'b0);
        sc <= 1'b0;
        run <= 1'b1;
        pause;
        chk({drv, men}, 2'h2);
        run <= 1'b0;
        pause;
        chk(drv, 1'b0);
        xfer(1'b1, ctrl_off, 32'h3, 1'b0);
        run <= 1'b1;
        cur <= 1'b1;
        pause;
        chk({drv, men}, 2'h3);
        run <= 1'b0;
        pause;
        chk({drv, men}, 2'h2);
        cur <= 1'b0;
        pause;
        chk(drv, 1'b0);
        xfer(1'b0, irq_status_off, 32'h0, 1'b0);
        run <= 1'b1;
        pause;
        // A reset in mid-run drops every output and restores the delays.
        presetn <= 1'b0;
        @(posedge pclk);
        chk({drv, men, irq}, 3'h0);
        presetn <= 1'b1;
        xfer(1'b0, run_dly_off, 32'(run_dly_reset), 1'b0);
        run <= 1'b0;
        end_of_test;
    end
    initial begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        end_of_test;
    end
endmodule // output_contactor_sequencer_tb_top
`default_nettype wire
